// File: hw/mac_checker.sv
`default_nettype none

module mac_checker
	import mac_pkg::*;
#(
	parameter int unsigned N_DATA = 4,
	parameter int unsigned N_PROG = 2,
	parameter int unsigned N_KEY  = 4,
	parameter int unsigned KEY_W  = 32
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire mac_req_t          req,
	output var  mac_rsp_t          rsp,
	input  wire mac_cfg_t          cfg,
	output logic                   cfg_ack,
	output logic                   cfg_err,
	input  wire logic              viol_clr,
	output logic                   viol_flag,
	output var  mac_addr_t         viol_addr,
	input  wire logic              noise,
	input  wire logic              key_we,
	input  wire logic [1:0]        key_idx,
	input  wire logic [KEY_W-1:0]  key_wdata,
	output logic [N_KEY*KEY_W-1:0] key_out
);

	// ----------------------------------------------------------------
	// Area storage and start-up state
	// ----------------------------------------------------------------
	mac_area_t  d_area [N_DATA];
	mac_area_t  p_area [N_PROG];
	mac_state_t state;
	mac_state_t next_state;

	// One init cycle after reset: areas hold their reset values before
	// the first request is judged, so nothing is granted from stale state.
	assign next_state = MAC_ST_RUN;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= MAC_ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	wire running = (state == MAC_ST_RUN);

	// ----------------------------------------------------------------
	// Configuration: range check against the physical memory type
	// ----------------------------------------------------------------
	// Data areas must sit in data memory, program areas in program memory.
	// An area reaching outside is refused as a whole rather than clipped,
	// so software never ends up with a region it did not ask for.
	wire cfg_order  = (cfg.area.first <= cfg.area.last);
	wire cfg_in_d   = (cfg.area.first >= DMEM_FIRST) && (cfg.area.last <= DMEM_LAST);
	wire cfg_in_p   = (cfg.area.first >= PMEM_FIRST) && (cfg.area.last <= PMEM_LAST);
	wire cfg_idx_ok = cfg.prog ? (32'(cfg.idx) < N_PROG) : (32'(cfg.idx) < N_DATA);
	wire cfg_ok     = cfg_order && cfg_idx_ok && (cfg.prog ? cfg_in_p : cfg_in_d);
	wire cfg_take   = cfg.we && running && cfg_ok;

	for (genvar i = 0; i < N_DATA; i++) begin : g_darea
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				d_area[i] <= AREA_RST;
			end else if (cfg_take && !cfg.prog && (32'(cfg.idx) == i)) begin
				d_area[i] <= cfg.area;
			end
		end
	end

	for (genvar i = 0; i < N_PROG; i++) begin : g_parea
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				p_area[i] <= AREA_RST;
			end else if (cfg_take && cfg.prog && (32'(cfg.idx) == i)) begin
				p_area[i] <= cfg.area;
			end
		end
	end

	// Configuration answers one cycle after the write strobe.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfg_ack <= 1'b0;
			cfg_err <= 1'b0;
		end else begin
			cfg_ack <= cfg_take;
			cfg_err <= cfg.we && !cfg_take;
		end
	end

	// ----------------------------------------------------------------
	// Area hit decode
	// ----------------------------------------------------------------
	logic [N_DATA-1:0] d_hit;
	logic [N_DATA-1:0] d_ro;
	logic [N_DATA-1:0] d_wr;
	logic [N_PROG-1:0] p_ex;

	for (genvar i = 0; i < N_DATA; i++) begin : g_dhit
		assign d_hit[i] = (req.addr >= d_area[i].first) && (req.addr <= d_area[i].last);
		assign d_ro[i]  = d_hit[i] && d_area[i].right.ro;
		assign d_wr[i]  = d_hit[i] && d_area[i].right.wr;
	end

	for (genvar i = 0; i < N_PROG; i++) begin : g_phit
		assign p_ex[i] = (req.addr >= p_area[i].first) && (req.addr <= p_area[i].last)
			&& p_area[i].right.ex;
	end

	// The fixed scratch area grants writing unless a read-only area overlaps it; the boot area always
	// grants execute. Both are constants and cannot be moved by software.
	wire fix_d_hit = (req.addr >= FIXD_FIRST) && (req.addr <= FIXD_LAST);
	wire boot_hit  = (req.addr >= BOOT_FIRST) && (req.addr <= BOOT_LAST);
	wire sreg_hit  = (req.addr >= SREG_FIRST) && (req.addr <= SREG_LAST);
	wire rom_hit   = (req.addr >= ROM_FIRST) && (req.addr <= ROM_LAST);
	wire flsh_hit  = (req.addr >= FLSH_FIRST) && (req.addr <= FLSH_LAST);

	wire any_ro  = |d_ro;
	wire area_rd = any_ro || (|d_wr) || fix_d_hit;
	wire area_wr = ((|d_wr) || fix_d_hit) && !any_ro;
	wire area_ex = (|p_ex) || boot_hit;

	// ----------------------------------------------------------------
	// Fixed protection of security registers, ROM, Flash and boot area
	// ----------------------------------------------------------------
	// These windows override the configurable areas: the rights below are
	// wired in, so no configuration write can loosen them.
	wire fixed_hit = sreg_hit || rom_hit || flsh_hit;
	wire fixed_rd  = sreg_hit ? req.priv : (rom_hit ? req.priv : 1'b1);
	wire fixed_wr  = sreg_hit ? req.priv : (rom_hit ? 1'b0 : req.priv);
	wire is_rd     = (req.kind == MAC_RD);
	wire is_wr     = (req.kind == MAC_WR);
	wire is_fetch  = (req.kind == MAC_FETCH);

	// Decision uses only the requesting subject's own privilege bit.
	wire ok_rd  = fixed_hit ? fixed_rd : area_rd;
	wire ok_wr  = fixed_hit ? (fixed_wr && !boot_hit) : area_wr;
	wire ok_ex  = area_ex && !sreg_hit;
	wire permit = running && ((is_rd && ok_rd) || (is_wr && ok_wr) || (is_fetch && ok_ex));
	wire viol   = req.valid && !permit;

	// ----------------------------------------------------------------
	// Response and sticky violation record
	// ----------------------------------------------------------------
	// The core must not complete an access until grant is seen, so a refused
	// access is blocked in the cycle that reports it.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rsp <= '{valid: 1'b0, grant: 1'b0, viol: 1'b0};
		end else begin
			rsp.valid <= req.valid;
			rsp.grant <= req.valid && permit;
			rsp.viol  <= viol;
		end
	end

	// A new violation wins over a clear in the same cycle.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			viol_flag <= 1'b0;
			viol_addr <= '0;
		end else begin
			viol_flag <= viol || (viol_flag && !viol_clr);
			if (viol) begin
				viol_addr <= req.addr;
			end
		end
	end

	// ----------------------------------------------------------------
	// Cipher key registers
	// ----------------------------------------------------------------
	logic [RNG_SYNC-1:0] noise_sync;
	logic [KEY_W-1:0]    pool;
	logic [KEY_W-1:0]    key [N_KEY];

	// The noise pin is asynchronous; only the second stage feeds the pool.
	always_ff @(posedge mclk) begin
		noise_sync <= {noise_sync[0], noise};
	end

	// The pool is never reset so that it keeps gathering noise across
	// resets; a reset too short to refill it leaves old bits mixed in.
	// Plain noise bits shift in with no feedback tap, so unknown start-up
	// contents are flushed after KEY_W cycles instead of circulating forever.
	always_ff @(posedge mclk) begin
		pool <= {pool[KEY_W-2:0], noise_sync[1]};
	end

	// While reset is held the keys shift fresh pool bits through, wiping
	// whatever secret they held.
	for (genvar i = 0; i < N_KEY; i++) begin : g_key
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				key[i] <= (i == 0) ? pool : key[(i == 0) ? 0 : i-1];
			end else if (key_we && (32'(key_idx) == i)) begin
				key[i] <= key_wdata;
			end
		end
		assign key_out[i*KEY_W +: KEY_W] = key[i];
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	init_no_grant_a: assert property ((state == MAC_ST_INIT) |=> !rsp.grant)
		else $error("grant issued during init cycle");

	read_in_area_a: assert property ((req.valid && is_rd && !fixed_hit && running)
		|=> (rsp.grant == $past(area_rd)))
		else $error("data read decision disagrees with areas");

	write_needs_wr_a: assert property ((req.valid && is_wr && !fixed_hit
		&& !(|d_wr) && !fix_d_hit) |=> !rsp.grant)
		else $error("write granted without writing right");

	write_ro_veto_a: assert property ((req.valid && is_wr && any_ro) |=> !rsp.grant)
		else $error("write granted inside read-only area");

	fetch_exec_a: assert property ((req.valid && is_fetch && !area_ex) |=> rsp.viol)
		else $error("fetch outside execute area not flagged");

	viol_is_refusal_a: assert property (rsp.valid |-> (rsp.viol == !rsp.grant))
		else $error("violation and grant not complementary");

	rom_write_off_a: assert property ((req.valid && is_wr && rom_hit) |=> rsp.viol)
		else $error("ROM write not refused");

	sreg_subject_a: assert property ((req.valid && (is_rd || is_wr) && sreg_hit)
		|=> (rsp.grant == ($past(req.priv) && $past(running))))
		else $error("security register access not tied to subject");

	cfg_range_a: assert property ((cfg.we && cfg.prog && !cfg_in_p) |=> cfg_err)
		else $error("out of range area accepted");

	sticky_flag_a: assert property ((viol_flag && !viol_clr) |=> viol_flag[*2] or
		(viol_flag ##1 $fell(viol_flag)))
		else $error("violation flag dropped without clear");

	viol_set_a: assert property (viol |=> viol_flag && (viol_addr == $past(req.addr)))
		else $error("violation not recorded");

	key_write_a: assert property (key_we |=> (key[$past(key_idx)] == $past(key_wdata)))
		else $error("key overwrite lost");

	cover_ro_veto_c: cover property (req.valid && is_wr && any_ro && (|d_wr));
	cover_fetch_ok_c: cover property (req.valid && is_fetch ##1 rsp.grant);
	cover_viol_clear_c: cover property (viol_flag && viol_clr && !viol ##1 !viol_flag);

endmodule : mac_checker

`default_nettype wire

// File: common/mac_pkg.sv
// Contract
// - Data access needs readable or writable area
// - Data write needs an area granting writing
// - Any overlapping read-only area refuses writes
// - Fetch needs a program area with execute
// - Every ungranted access is a reported violation
// - Reset defines all areas and rights first
// - Areas stay inside their memory type range
// - Security registers, ROM, Flash, boot fixed-protected
// - ROM and Flash attributes fixed, not writable
// - Reset randomizes keys; software may overwrite
// - Each request judged on its own subject
`default_nettype none

package mac_pkg;

	// ----------------------------------------------------------------
	// Address map and widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 16;
	typedef logic [ADDR_W-1:0] mac_addr_t;

	// Physical data memory and security register window.
	localparam mac_addr_t DMEM_FIRST = 16'h0000;
	localparam mac_addr_t DMEM_LAST  = 16'h3fff;
	localparam mac_addr_t SREG_FIRST = 16'h4000;
	localparam mac_addr_t SREG_LAST  = 16'h40ff;
	// Physical program memory: ROM then Flash, boot area at ROM start.
	localparam mac_addr_t PMEM_FIRST = 16'h8000;
	localparam mac_addr_t PMEM_LAST  = 16'hffff;
	localparam mac_addr_t ROM_FIRST  = 16'h8000;
	localparam mac_addr_t ROM_LAST   = 16'hbfff;
	localparam mac_addr_t FLSH_FIRST = 16'hc000;
	localparam mac_addr_t FLSH_LAST  = 16'hffff;
	localparam mac_addr_t BOOT_FIRST = 16'h8000;
	localparam mac_addr_t BOOT_LAST  = 16'h80ff;
	// Fixed data area (scratch, writable unless a read-only area overlaps) inside data memory.
	localparam mac_addr_t FIXD_FIRST = 16'h0000;
	localparam mac_addr_t FIXD_LAST  = 16'h00ff;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MAC_RD    = 2'h0,
		MAC_WR    = 2'h1,
		MAC_FETCH = 2'h2
	} mac_kind_t;

	typedef enum logic [1:0] {
		MAC_ST_INIT = 2'b01,
		MAC_ST_RUN  = 2'b10
	} mac_state_t;

	typedef struct packed {
		logic ro;
		logic wr;
		logic ex;
	} mac_right_t;

	typedef struct packed {
		mac_addr_t  first;
		mac_addr_t  last;
		mac_right_t right;
	} mac_area_t;

	typedef struct packed {
		logic      valid;
		mac_kind_t kind;
		logic      priv;
		mac_addr_t addr;
	} mac_req_t;

	typedef struct packed {
		logic valid;
		logic grant;
		logic viol;
	} mac_rsp_t;

	typedef struct packed {
		logic       we;
		logic       prog;
		logic [2:0] idx;
		mac_area_t  area;
	} mac_cfg_t;

	// Every configurable area comes out of reset covering only address 16'h0000 and without rights.
	localparam mac_area_t AREA_RST = '{first: 16'h0000, last: 16'h0000,
		right: '{ro: 1'b0, wr: 1'b0, ex: 1'b0}};
	localparam int unsigned RNG_SYNC = 2;

endpackage : mac_pkg

`default_nettype wire

// File: test/mac_core_model.sv
`default_nettype none

module mac_core_model
	import mac_pkg::*;
(
	input  wire logic     mclk,
	input  wire mac_rsp_t rsp,
	output var  mac_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	// The core starts with no request on the bus.
	initial begin
		req = '0;
	end

	// One access, issued at a falling edge, with its answer taken one cycle on.
	// An idle bus carries inverted leftovers, so a stale request never looks fresh.
	task automatic issue(input mac_kind_t k, input logic p, input mac_addr_t a,
		output logic ok, output logic g, output logic v);
		req = '{valid: 1'b1, kind: k, priv: p, addr: a};
		@(negedge mclk);
		ok = rsp.valid;
		g = rsp.grant;
		v = rsp.viol;
		req = '{valid: 1'b0, kind: k, priv: ~p, addr: ~a};
		@(negedge mclk);
		ok = ok & ~rsp.valid; // The answer stands for one cycle only.
	endtask : issue
endmodule : mac_core_model

`default_nettype wire

// File: test/memory_area_access_checker_tb.sv
`default_nettype none

module memory_area_access_checker_tb
	import mac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic         mclk, sys_rst, viol_clr, viol_flag, noise, key_we, cfg_ack, cfg_err;
	mac_req_t     req;
	mac_rsp_t     rsp;
	mac_cfg_t     cfg;
	mac_addr_t    viol_addr;
	logic [1:0]   key_idx;
	logic [31:0]  key_wdata;
	logic [127:0] key_out;
	int           num_errors, compares;

	mac_checker #(.N_DATA(4), .N_PROG(2), .N_KEY(4), .KEY_W(32)) dut (
		.mclk(mclk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .cfg(cfg),
		.cfg_ack(cfg_ack), .cfg_err(cfg_err), .viol_clr(viol_clr),
		.viol_flag(viol_flag), .viol_addr(viol_addr), .noise(noise),
		.key_we(key_we), .key_idx(key_idx), .key_wdata(key_wdata), .key_out(key_out));
	mac_core_model core (.mclk(mclk), .rsp(rsp), .req(req));

	// Clock at 40 MHz and an unrelated entropy toggle.
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		noise = 1'b0;
		forever #37 noise = ~noise;
	end

	// ----------------------------------------------------------------
	// Checks and bus tasks
	// ----------------------------------------------------------------
	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk1

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk32

	// A refused access must also leave the sticky flag and its address behind.
	task automatic acc(input mac_kind_t k, input logic p, input mac_addr_t a, input logic g_exp);
		logic ok, g, v;
		core.issue(k, p, a, ok, g, v);
		chk1(ok, 1'b1);
		chk1(g, g_exp);
		chk1(v, ~g_exp);
		if (!g_exp) begin
			chk1(viol_flag, 1'b1);
			chk32({16'h0000, viol_addr}, {16'h0000, a});
		end
	endtask : acc

	task automatic cfg_wr(input logic p, input logic [2:0] i, input mac_addr_t f,
		input mac_addr_t l, input mac_right_t r, input logic ok);
		cfg = '{we: 1'b1, prog: p, idx: i, area: '{first: f, last: l, right: r}};
		@(negedge mclk);
		chk1(cfg_ack, ok);
		chk1(cfg_err, ~ok);
		cfg.we = 1'b0;
		@(negedge mclk);
	endtask : cfg_wr

	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (12) @(negedge mclk);
		sys_rst = 1'b0;
	endtask : do_reset

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_init();
		acc(MAC_RD, 1'b0, 16'h0010, 1'b0);
		acc(MAC_RD, 1'b0, 16'h1000, 1'b0);
		acc(MAC_RD, 1'b0, 16'h0010, 1'b1);
		acc(MAC_WR, 1'b0, 16'h00ff, 1'b1);
	endtask : t_init

	task automatic t_data();
		cfg_wr(1'b0, 3'h0, 16'h1000, 16'h1fff, 3'h2, 1'b1);
		acc(MAC_WR, 1'b0, 16'h1800, 1'b1);
		acc(MAC_RD, 1'b0, 16'h1fff, 1'b1);
		acc(MAC_RD, 1'b0, 16'h2000, 1'b0);
		cfg_wr(1'b0, 3'h1, 16'h1800, 16'h18ff, 3'h4, 1'b1);
		acc(MAC_WR, 1'b0, 16'h18ff, 1'b0);
		acc(MAC_RD, 1'b0, 16'h1800, 1'b1);
		acc(MAC_WR, 1'b0, 16'h1900, 1'b1);
		cfg_wr(1'b0, 3'h2, 16'h2000, 16'h1000, 3'h2, 1'b0);
		cfg_wr(1'b0, 3'h2, 16'h3f00, 16'h4000, 3'h2, 1'b0);
		cfg_wr(1'b1, 3'h0, 16'h7f00, 16'h8100, 3'h1, 1'b0);
		cfg_wr(1'b0, 3'h4, 16'h2000, 16'h20ff, 3'h2, 1'b0);
	endtask : t_data

	task automatic t_prog();
		acc(MAC_FETCH, 1'b0, 16'h80ff, 1'b1);
		acc(MAC_FETCH, 1'b0, 16'h8100, 1'b0);
		cfg_wr(1'b1, 3'h0, 16'hc000, 16'hc0ff, 3'h1, 1'b1);
		acc(MAC_FETCH, 1'b0, 16'hc0ff, 1'b1);
		acc(MAC_FETCH, 1'b0, 16'hc100, 1'b0);
		cfg_wr(1'b1, 3'h1, 16'h9000, 16'h90ff, 3'h4, 1'b1);
		acc(MAC_FETCH, 1'b0, 16'h9000, 1'b0);
		acc(MAC_FETCH, 1'b0, 16'h1000, 1'b0);
	endtask : t_prog

	// Fixed windows win over areas and judge each request by its own privilege.
	task automatic t_fixed();
		acc(MAC_RD, 1'b1, 16'h4000, 1'b1);
		acc(MAC_RD, 1'b0, 16'h4000, 1'b0);
		acc(MAC_WR, 1'b1, 16'h40ff, 1'b1);
		acc(MAC_FETCH, 1'b1, 16'h4010, 1'b0);
		acc(MAC_WR, 1'b1, 16'h8000, 1'b0);
		acc(MAC_RD, 1'b1, 16'hbfff, 1'b1);
		acc(MAC_RD, 1'b0, 16'h9000, 1'b0);
		acc(MAC_WR, 1'b0, 16'hc000, 1'b0);
		acc(MAC_WR, 1'b1, 16'hffff, 1'b1);
		acc(MAC_RD, 1'b0, 16'hc000, 1'b1);
	endtask : t_fixed

	task automatic t_flag();
		acc(MAC_RD, 1'b0, 16'h3000, 1'b0);
		acc(MAC_RD, 1'b0, 16'h0010, 1'b1);
		chk1(viol_flag, 1'b1);
		chk32({16'h0000, viol_addr}, 32'h0000_3000);
		viol_clr = 1'b1;
		@(negedge mclk);
		viol_clr = 1'b0;
		@(negedge mclk);
		chk1(viol_flag, 1'b0);
		// A clear in the cycle of a new violation loses to the violation.
		viol_clr = 1'b1;
		fork
			acc(MAC_RD, 1'b0, 16'h2000, 1'b0);
			begin
				@(negedge mclk);
				viol_clr = 1'b0;
			end
		join
	endtask : t_flag

	// Back-to-back key writes, then a reset that must wipe them and the areas.
	task automatic t_key();
		key_we = 1'b1;
		key_idx = 2'h2;
		key_wdata = 32'h5ac3_9e1f;
		@(negedge mclk);
		key_idx = 2'h0;
		key_wdata = 32'h0123_4567;
		@(negedge mclk);
		key_we = 1'b0;
		chk32(key_out[95:64], 32'h5ac3_9e1f);
		chk32(key_out[31:0], 32'h0123_4567);
		do_reset();
		chk1(viol_flag, 1'b0);
		acc(MAC_RD, 1'b0, 16'h0010, 1'b0);
		acc(MAC_RD, 1'b0, 16'h1800, 1'b0);
		chk1(key_out[95:64] !== 32'h5ac3_9e1f, 1'b1);
		chk1(key_out[31:0] !== 32'h0123_4567, 1'b1);
		chk1((^key_out[95:64]) === 1'bx, 1'b0);
		acc(MAC_WR, 1'b0, 16'h1800, 1'b0);
	endtask : t_key

	task automatic conclude();
		if (num_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	// Main sequence.
	initial begin
		num_errors = 0;
		compares = 0;
		sys_rst = 1'b1;
		cfg = '0;
		viol_clr = 1'b0;
		key_we = 1'b0;
		key_idx = 2'h0;
		key_wdata = 32'h0000_0000;
		do_reset();
		t_init();
		t_data();
		t_prog();
		t_fixed();
		t_flag();
		t_key();
		conclude();
	end

	// A hang is cut short and counted.
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		conclude();
	end
endmodule : memory_area_access_checker_tb

`default_nettype wire
